// [common/led_backlight_pkg.sv]
// constants and carriers for the led backlight group controller
// assumes a single 100 MHz clock and synchronous control inputs
//
// Overview of operation
// [RULE1] sub input steers sub group, main input steers main group together
// [RULE2] sinks one to four are main, five and six are sub
// [RULE3] sub low, main pulsing: sub off, main follows pulses
// [RULE4] sub pulsing, main low: main off, sub follows pulses
// [RULE5] sub pulsing, main high: main steady on, sub follows pulses
// [RULE6] sub high, main pulsing: sub steady on, main follows pulses
// [RULE7] both pulsing: each group follows its own input
// [RULE8] pulses from 100 Hz to 200 kHz switch sinks each pulse
// [RULE9] enabled sink carries zero or full current, average scales with duty
// [RULE10] sinks only fully off or fully on
// [RULE11] both inputs low disables all sinks immediately
// [RULE12] pump keeps running 15 ms after both low, then shuts down
// [RULE13] input returning high cancels pending shutdown, timer restarts later
// [RULE14] controller drives steady levels when not pulsing
// [RULE15] controller keeps pulse rate near or above 100 Hz
// [RULE16] 1.5x to 2x at 3.33 V falling, back at 3.36 V rising
// [RULE17] 1x to 1.5x at 4.77 V falling, back at 4.81 V rising
// [RULE18] gain is three-state machine, one step per decision
package led_backlight_pkg;
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned HOLDOFF_MS = 15;
    localparam int unsigned HOLDOFF_CYCLES = CLOCK_HZ / 1000 * HOLDOFF_MS;
    localparam int unsigned MAIN_SINKS = 4;
    localparam int unsigned SUB_SINKS = 2;

    typedef enum logic [2:0] {
        GAIN_1X = 3'h1,
        GAIN_1P5X = 3'h2,
        GAIN_2X = 3'h4
    } gain_e;
    localparam gain_e GAIN_RESET = GAIN_1P5X;

    // supply comparator flags, each already hysteretic
    typedef struct packed {
        logic below_low; // supply at or under 3.33, released at 3.36
        logic below_high; // supply at or under 4.77, released at 4.81
    } supply_flags_s;

    typedef struct packed {
        logic [MAIN_SINKS-1:0] main_sink_channels;
        logic sub_sink_channel_a;
        logic sub_sink_channel_b;
    } sink_enables_s;
endpackage

// [core/led_backlight_group_ctrl.sv]
// control logic for six led current sinks in two groups
// assumes control inputs synchronous to clock and driven steadily
`timescale 1ns/10ps
`default_nettype none
module led_backlight_group_ctrl
#(
    parameter int unsigned HOLDOFF_CYCLES = led_backlight_pkg::HOLDOFF_CYCLES
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sub_group_ctrl_in,
    input wire logic main_group_ctrl_in,
    input wire led_backlight_pkg::supply_flags_s supply_flags,
    output led_backlight_pkg::sink_enables_s sinks,
    output logic pump_run,
    output led_backlight_pkg::gain_e pump_gain
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sink enables, full on or full off only, one cycle from input
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sinks <= '0;
        else
        begin
            // RULE1
            sinks.main_sink_channels <= {led_backlight_pkg::MAIN_SINKS{
                main_group_ctrl_in}}; // RULE2
            sinks.sub_sink_channel_a <= sub_group_ctrl_in; // RULE2
            sinks.sub_sink_channel_b <= sub_group_ctrl_in; // RULE2
            // RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pump hold-off
    localparam int unsigned CW = $clog2(HOLDOFF_CYCLES + 1);
    logic [CW-1:0] holdoff;
    logic any_high;

    assign any_high = sub_group_ctrl_in | main_group_ctrl_in;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            holdoff <= '0;
        else if (any_high)
            holdoff <= '0; // RULE13
        else if (holdoff != CW'(HOLDOFF_CYCLES))
            holdoff <= holdoff + 1'b1; // RULE12
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pump_run <= 1'b0;
        else if (any_high)
            pump_run <= 1'b1; // RULE13
        else if (holdoff == CW'(HOLDOFF_CYCLES - 1))
            pump_run <= 1'b0; // RULE12
    end

    ////////////////////////////////////////////////////////////////////////
    // gain selection
    pump_gain_select gain_sel
    (
        .clock(clock),
        .rst_n(rst_n),
        .flags(supply_flags),
        .gain(pump_gain)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_main_follows: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> sinks.main_sink_channels
            == {led_backlight_pkg::MAIN_SINKS{$past(main_group_ctrl_in)}})
        else $error("main sinks not following input"); // RULE3
    a_sub_follows: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> sinks.sub_sink_channel_a == $past(sub_group_ctrl_in)
            && sinks.sub_sink_channel_b == $past(sub_group_ctrl_in))
        else $error("sub sinks not following input"); // RULE4
    a_both_low_off: assert property (@(posedge clock) disable iff (!rst_n)
        !sub_group_ctrl_in && !main_group_ctrl_in
        |=> sinks == '0)
        else $error("sinks on after both low"); // RULE11
    a_pump_holds: assert property (@(posedge clock) disable iff (!rst_n)
        pump_run && !any_high && holdoff == '0
        |=> pump_run)
        else $error("pump stopped early"); // RULE12
    a_pump_stops: assert property (@(posedge clock) disable iff (!rst_n)
        holdoff == CW'(HOLDOFF_CYCLES) |-> !pump_run)
        else $error("pump still running after hold-off"); // RULE12
    a_pump_rearm: assert property (@(posedge clock) disable iff (!rst_n)
        any_high |=> pump_run && holdoff == '0)
        else $error("hold-off not cancelled"); // RULE13

    ////////////////////////////////////////////////////////////////////////
    // group steering checks
    a_groups_apart: assert property (@(posedge clock) disable iff (!rst_n)
        sub_group_ctrl_in && !main_group_ctrl_in
        |=> sinks.main_sink_channels == '0 && sinks.sub_sink_channel_a)
        else $error("groups not steered apart"); // RULE1

    a_sub_pair_same: assert property (@(posedge clock) disable iff (!rst_n)
        sinks.sub_sink_channel_a == sinks.sub_sink_channel_b)
        else $error("sub sinks differ"); // RULE2

    a_sub_off_low: assert property (@(posedge clock) disable iff (!rst_n)
        !sub_group_ctrl_in
        |=> !sinks.sub_sink_channel_a && !sinks.sub_sink_channel_b)
        else $error("sub sinks on with sub input low"); // RULE3

    a_main_off_low: assert property (@(posedge clock) disable iff (!rst_n)
        !main_group_ctrl_in |=> sinks.main_sink_channels == '0)
        else $error("main sinks on with main input low"); // RULE4

    a_main_steady_on: assert property (@(posedge clock) disable iff (!rst_n)
        main_group_ctrl_in |=> &sinks.main_sink_channels)
        else $error("main sinks not on with main input high"); // RULE5

    a_sub_steady_on: assert property (@(posedge clock) disable iff (!rst_n)
        sub_group_ctrl_in
        |=> sinks.sub_sink_channel_a && sinks.sub_sink_channel_b)
        else $error("sub sinks not on with sub input high"); // RULE6

    a_both_high_on: assert property (@(posedge clock) disable iff (!rst_n)
        sub_group_ctrl_in && main_group_ctrl_in |=> &sinks)
        else $error("not all sinks on with both high"); // RULE7

    a_sinks_need_pump: assert property (@(posedge clock) disable iff (!rst_n)
        sinks != '0 |-> pump_run)
        else $error("sinks on while pump stopped"); // RULE9

    a_main_all_same: assert property (@(posedge clock) disable iff (!rst_n)
        sinks.main_sink_channels == '0 || &sinks.main_sink_channels)
        else $error("main sinks partly on"); // RULE10

    ////////////////////////////////////////////////////////////////////////
    // hold-off timer checks
    a_holdoff_counts: assert property (@(posedge clock) disable iff (!rst_n)
        !any_high && holdoff != CW'(HOLDOFF_CYCLES)
        |=> holdoff == $past(holdoff) + 1'b1)
        else $error("hold-off not counting"); // RULE12

    a_holdoff_sat: assert property (@(posedge clock) disable iff (!rst_n)
        !any_high && holdoff == CW'(HOLDOFF_CYCLES)
        |=> holdoff == CW'(HOLDOFF_CYCLES))
        else $error("hold-off counter wrapped"); // RULE12

    a_pump_mid_hold: assert property (@(posedge clock) disable iff (!rst_n)
        pump_run && !any_high && holdoff != CW'(HOLDOFF_CYCLES - 1)
        |=> pump_run)
        else $error("pump stopped inside hold-off"); // RULE12

    a_pump_falls: assert property (@(posedge clock) disable iff (!rst_n)
        !any_high && holdoff == CW'(HOLDOFF_CYCLES - 1) |=> !pump_run)
        else $error("pump not stopped at hold-off end"); // RULE12

    a_pump_off_stays: assert property (@(posedge clock) disable iff (!rst_n)
        !pump_run && !any_high |=> !pump_run)
        else $error("pump started with both inputs low"); // RULE12
endmodule // led_backlight_group_ctrl
`default_nettype wire

// [core/pump_gain_select.sv]
// three-state pump gain selector
// assumes synchronous comparator flags and the synchronised reset
`timescale 1ns/10ps
`default_nettype none
module pump_gain_select
(
    input wire logic clock,
    input wire logic rst_n,
    input wire led_backlight_pkg::supply_flags_s flags,
    output led_backlight_pkg::gain_e gain
);
    led_backlight_pkg::gain_e next_gain;

    always_comb
    begin
        next_gain = gain;
        case (gain)
            led_backlight_pkg::GAIN_1X:
                if (flags.below_high)
                    next_gain = led_backlight_pkg::GAIN_1P5X; // RULE17
            led_backlight_pkg::GAIN_1P5X:
                if (flags.below_low)
                    next_gain = led_backlight_pkg::GAIN_2X; // RULE16
                else if (!flags.below_high)
                    next_gain = led_backlight_pkg::GAIN_1X; // RULE17
            led_backlight_pkg::GAIN_2X:
                if (!flags.below_low)
                    next_gain = led_backlight_pkg::GAIN_1P5X; // RULE16
            default:
                next_gain = led_backlight_pkg::GAIN_RESET;
        endcase
    end

    // one step per decision
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            gain <= led_backlight_pkg::GAIN_RESET;
        else
            gain <= next_gain; // RULE18
    end

    a_gain_one_step: assert property (@(posedge clock) disable iff (!rst_n)
        !((gain == led_backlight_pkg::GAIN_1X)
          && ($past(gain) == led_backlight_pkg::GAIN_2X))
        && !((gain == led_backlight_pkg::GAIN_2X)
          && ($past(gain) == led_backlight_pkg::GAIN_1X)))
        else $error("gain jumped two steps"); // RULE18
    a_gain_up_low: assert property (@(posedge clock) disable iff (!rst_n)
        (gain == led_backlight_pkg::GAIN_1P5X) && flags.below_low
        |=> gain == led_backlight_pkg::GAIN_2X)
        else $error("no step to 2x"); // RULE16
    a_gain_down_low: assert property (@(posedge clock) disable iff (!rst_n)
        (gain == led_backlight_pkg::GAIN_2X) && !flags.below_low
        |=> gain == led_backlight_pkg::GAIN_1P5X)
        else $error("no step back to 1.5x"); // RULE16
    a_gain_high_pair: assert property (@(posedge clock) disable iff (!rst_n)
        (gain == led_backlight_pkg::GAIN_1X) && flags.below_high
        |=> gain == led_backlight_pkg::GAIN_1P5X)
        else $error("no step to 1.5x"); // RULE17
endmodule // pump_gain_select
`default_nettype wire

// [verification/ctrl_pulse_source.sv]
// pulse source standing in for the host at both control inputs
// assumes the bench sets level, pulse enable and duty
`timescale 1ns/10ps
`default_nettype none
module ctrl_pulse_source
(
    input wire logic clock,
    input wire logic [1:0] level,
    input wire logic [1:0] pwm_on,
    input wire logic [3:0] duty,
    output logic sub_out = 1'b0,
    output logic main_out = 1'b0
);
    logic [3:0] phase = 4'h0;
    ////////////////////////////////////////////////////////////////////////
    // pulse period of sixteen clocks, steady levels otherwise
    always @(negedge clock)
    begin
        phase <= phase + 4'h1;
        sub_out <= pwm_on[1] ? (phase < duty) : level[1];
        main_out <= pwm_on[0] ? (phase < ~duty) : level[0];
    end
endmodule // ctrl_pulse_source
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the led backlight group controller
// assumes the pulse source model and a 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int unsigned HOLD = 20;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic sub_in;
    logic main_in;
    logic [1:0] level = 2'h0;
    logic [1:0] pwm_on = 2'h0;
    logic [3:0] duty = 4'h0;
    led_backlight_pkg::supply_flags_s flags = 2'h1;
    led_backlight_pkg::sink_enables_s sinks;
    led_backlight_pkg::gain_e gain;
    led_backlight_pkg::gain_e exp_gain = led_backlight_pkg::GAIN_1P5X;
    logic pump;
    logic exp_pump = 1'b0;
    logic [5:0] exp_sinks = 6'h00;
    int cnt = 0;
    int err_count = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h0000_5a3e;
    always #5 clock = ~clock;
    ctrl_pulse_source u_src (.clock(clock), .level(level), .pwm_on(pwm_on),
        .duty(duty), .sub_out(sub_in), .main_out(main_in));
    led_backlight_group_ctrl #(.HOLDOFF_CYCLES(HOLD)) u_dut (.clock(clock),
        .arst_n(arst_n), .sub_group_ctrl_in(sub_in),
        .main_group_ctrl_in(main_in), .supply_flags(flags), .sinks(sinks),
        .pump_run(pump), .pump_gain(gain));
    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic led_backlight_pkg::supply_flags_s rand_flags();
        logic [31:0] r;
        r = xorshift();
        return r[0] ? 2'h1 : {r[1], r[1]};
    endfunction
    function automatic led_backlight_pkg::gain_e gain_step(
        input led_backlight_pkg::gain_e g,
        input led_backlight_pkg::supply_flags_s f);
        led_backlight_pkg::gain_e t;
        t = f.below_low ? led_backlight_pkg::GAIN_2X :
            f.below_high ? led_backlight_pkg::GAIN_1P5X :
            led_backlight_pkg::GAIN_1X;
        if (g == t || g == led_backlight_pkg::GAIN_1P5X)
            return t;
        return led_backlight_pkg::GAIN_1P5X;
    endfunction
    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reference model and comparisons
    always @(posedge clock)
    begin
        exp_sinks <= {{4{main_in}}, sub_in, sub_in};
        exp_gain <= gain_step(exp_gain, flags);
        cnt <= (sub_in | main_in) ? 0 : cnt + 1;
        exp_pump <= exp_pump | sub_in | main_in;
    end
    always @(negedge clock)
    begin
        check(sinks, exp_sinks);
        check({3'h0, gain}, {3'h0, exp_gain});
        check({5'h0, pump}, {5'h0, exp_pump & (cnt < HOLD)});
    end
    ////////////////////////////////////////////////////////////////////////
    // mode table, then hold-off cancel and expiry
    initial
    begin
        repeat (4) @(posedge clock);
        @(negedge clock) arst_n <= 1'b1;
        repeat (3) @(negedge clock);
        for (int m = 0; m < 9; m++)
        begin
            level <= {m / 3 == 1, m % 3 == 1};
            pwm_on <= {m / 3 == 2, m % 3 == 2};
            repeat (40)
            begin
                @(negedge clock);
                duty <= 4'(xorshift());
                flags <= rand_flags();
            end
        end
        pwm_on <= 2'h0;
        level <= 2'h0;
        repeat (HOLD - 3) @(negedge clock);
        level <= 2'h1;
        @(negedge clock) level <= 2'h0;
        repeat (HOLD + 10) @(negedge clock);
        level <= 2'h3;
        repeat (5) @(negedge clock);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
